// *** hdl/uspr_top.sv ***
// serial port: axi4-lite registers, fifos, baud generator, transmitter, receiver
`timescale 1ns/100ps
`include "uspr_regs.svh"

// How it works
// - tx idle flag set only when tx fifo empty and shifter finished.
// - parity error flag follows head byte, refreshed on read, cleared empty.
// - framing error flag follows head byte, refreshed on read, cleared empty.
// - overrun flag sets on arrival into full rx fifo, cleared by read.
// - tx space flag set while tx fifo can take another byte.
// - rx available flag set while rx fifo holds any byte.
// - with flow on, auto mode drops request-to-send when only one rx slot remains.
// - manual request-to-send bit is ignored while auto mode is on.
// - handshake enable lets clear-to-send pause the transmitter.
// - odd select chooses odd parity, otherwise even.
// - parity enable adds and checks a parity bit.
// - two stop select sends two stop bits instead of one.
// - eight bit select picks eight data bits, else seven.
// - flow on, auto off: manual bit drives request-to-send directly.
// - bit rate is 24 MHz over twice period plus fraction.
// - fraction bit adds one half step, allowing odd divisors.
// - status word is 0x40 right after reset; the first bus read returns 0x44.
// - data write pushes tx fifo; read pops rx fifo, clears overrun.
// - data read loads error flags of next byte, zero when empty.
module uspr_top
    import uspr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_in,
    output logic tx_out,
    input wire logic clear_to_send_in_n,
    output logic request_to_send_out_n
);
    function automatic logic uspr_hit(input logic [15:0] a,
                                      input logic [15:0] off);
        return a[15:2] == off[15:2];
    endfunction : uspr_hit

    localparam logic [2:0] DEPTH = 3'(`USPR_FIFO_DEPTH);

    // ---- registers and bus state
    logic [6:0] cfg_reg;
    logic [15:0] per_reg;
    logic frac_reg;
    logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
    logic [1:0] bresp_reg;
    logic [15:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic arready_reg, rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic ovf_reg, par_err_reg, frm_err_reg, rts_n_reg;

    wire flow = cfg_reg[`USPR_CF_FLOW];
    wire auto_rts = cfg_reg[`USPR_CF_AUTO];
    wire odd_sel = cfg_reg[`USPR_CF_ODD];
    wire par_en = cfg_reg[`USPR_CF_PAR];
    wire two_stop = cfg_reg[`USPR_CF_TWOSTP];
    wire eight = cfg_reg[`USPR_CF_EIGHT];
    wire [2:0] last_bit = eight ? 3'd7 : 3'd6;

    // ---- fifos
    logic [7:0] txf_mem [0:`USPR_FIFO_DEPTH-1];
    logic [9:0] rxf_mem [0:`USPR_FIFO_DEPTH-1];
    logic [`USPR_PTR_W-1:0] txf_wr_reg, txf_rd_reg, rxf_wr_reg, rxf_rd_reg;
    logic [2:0] txf_cnt_reg, rxf_cnt_reg;

    // ---- 24 MHz reference from 125 MHz by phase accumulation
    logic [7:0] ref_acc_reg;
    wire [7:0] ref_sum = ref_acc_reg + 8'(`USPR_REF_MHZ);
    wire ref_tick = ref_sum >= 8'(`USPR_CLK_MHZ);
    wire [7:0] ref_acc_next = ref_tick ? ref_sum - 8'(`USPR_CLK_MHZ)
                                       : ref_sum;
    // divisor counts whole ticks of the reference, two per period step
    wire [16:0] div_raw = {per_reg, 1'b0} + {16'h0000, frac_reg};
    wire [16:0] div_eff = (div_raw == 17'h0) ? 17'h1 : div_raw;
    wire [16:0] div_last = div_eff - 17'h1;
    wire [16:0] half_last = (div_eff[16:1] == 16'h0) ? 17'h0
                                                     : {1'b0, div_eff[16:1]} - 17'h1;

    // ---- bus decode
    wire aw_hs = s_axi_awvalid & awready_reg;
    wire w_hs = s_axi_wvalid & wready_reg;
    wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
    wire aw_full_next = (aw_full_reg | aw_hs) & ~do_write;
    wire w_full_next = (w_full_reg | w_hs) & ~do_write;
    wire ar_hs = s_axi_arvalid & arready_reg;
    wire rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);
    wire wr_cfg = do_write & uspr_hit(awaddr_reg, `USPR_OFF_CFG);
    wire wr_per = do_write & uspr_hit(awaddr_reg, `USPR_OFF_PER);
    wire wr_frac = do_write & uspr_hit(awaddr_reg, `USPR_OFF_FRAC);
    wire wr_data = do_write & uspr_hit(awaddr_reg, `USPR_OFF_DATA)
                   & wstrb_reg[0];
    wire wr_ok = uspr_hit(awaddr_reg, `USPR_OFF_CFG)
                 | uspr_hit(awaddr_reg, `USPR_OFF_PER)
                 | uspr_hit(awaddr_reg, `USPR_OFF_FRAC)
                 | uspr_hit(awaddr_reg, `USPR_OFF_DATA)
                 | uspr_hit(awaddr_reg, `USPR_OFF_STAT);
    wire rd_stat = ar_hs & uspr_hit(s_axi_araddr, `USPR_OFF_STAT);
    wire rd_data = ar_hs & uspr_hit(s_axi_araddr, `USPR_OFF_DATA);
    wire rd_ok = uspr_hit(s_axi_araddr, `USPR_OFF_STAT)
                 | uspr_hit(s_axi_araddr, `USPR_OFF_CFG)
                 | uspr_hit(s_axi_araddr, `USPR_OFF_PER)
                 | uspr_hit(s_axi_araddr, `USPR_OFF_FRAC)
                 | uspr_hit(s_axi_araddr, `USPR_OFF_DATA);

    // ---- transmit side
    uspr_tx_state_t tx_state_reg, tx_state_next;
    logic [16:0] tx_tim_reg;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic [2:0] tx_bit_reg, tx_bit_next;
    logic tx_par_reg, tx_par_next, tx_out_reg, tx_out_next;
    wire tx_full = txf_cnt_reg == DEPTH;
    wire tx_push = wr_data & ~tx_full;
    wire cts_block = flow & clear_to_send_in_n;
    wire tx_pop = (tx_state_reg == USPR_TX_IDLE) & (txf_cnt_reg != 3'd0)
                  & ~cts_block;
    wire tx_bit_end = ref_tick & (tx_tim_reg >= div_last);
    wire tx_idle_flag = (txf_cnt_reg == 3'd0)
                        & (tx_state_reg == USPR_TX_IDLE);
    // space flag is a flop held low in reset so status starts at 0x40
    logic tx_space_reg;
    wire [2:0] txf_cnt_next = txf_cnt_reg + {2'b0, tx_push}
                              - {2'b0, tx_pop};

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_bit_next = tx_bit_reg;
        tx_par_next = tx_par_reg;
        tx_out_next = tx_out_reg;
        unique case (tx_state_reg)
            USPR_TX_IDLE: begin
                tx_out_next = 1'b1;
                if (tx_pop) begin
                    tx_shift_next = txf_mem[txf_rd_reg];
                    tx_par_next = odd_sel;
                    tx_out_next = 1'b0;
                    tx_state_next = USPR_TX_START;
                end
            end
            USPR_TX_START: begin
                if (tx_bit_end) begin
                    tx_out_next = tx_shift_reg[0];
                    tx_par_next = tx_par_reg ^ tx_shift_reg[0];
                    tx_bit_next = 3'd0;
                    tx_state_next = USPR_TX_DATA;
                end
            end
            USPR_TX_DATA: begin
                if (tx_bit_end) begin
                    if (tx_bit_reg == last_bit) begin
                        tx_bit_next = 3'd0;
                        if (par_en) begin
                            tx_out_next = tx_par_reg;
                            tx_state_next = USPR_TX_PAR;
                        end else begin
                            tx_out_next = 1'b1;
                            tx_state_next = USPR_TX_STOP;
                        end
                    end else begin
                        tx_shift_next = {1'b0, tx_shift_reg[7:1]};
                        tx_out_next = tx_shift_reg[1];
                        tx_par_next = tx_par_reg ^ tx_shift_reg[1];
                        tx_bit_next = tx_bit_reg + 3'd1;
                    end
                end
            end
            USPR_TX_PAR: begin
                if (tx_bit_end) begin
                    tx_out_next = 1'b1;
                    tx_state_next = USPR_TX_STOP;
                end
            end
            USPR_TX_STOP: begin
                if (tx_bit_end) begin
                    if (two_stop && tx_bit_reg == 3'd0) begin
                        tx_bit_next = 3'd1;
                    end else begin
                        tx_state_next = USPR_TX_IDLE;
                    end
                end
            end
        endcase
    end

    // ---- receive side
    uspr_rx_state_t rx_state_reg, rx_state_next;
    logic [16:0] rx_tim_reg;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic [2:0] rx_bit_reg, rx_bit_next;
    logic rx_par_reg, rx_par_next, rx_perr_reg, rx_perr_next;
    logic rx_push_req;
    logic rx_prev_reg;
    wire rx_sample = ref_tick & (rx_tim_reg >= ((rx_state_reg == USPR_RX_START)
                                 ? half_last : div_last));
    wire [7:0] rx_byte = eight ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};
    wire [9:0] rx_word = {~rx_in, rx_perr_reg, rx_byte};

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_bit_next = rx_bit_reg;
        rx_par_next = rx_par_reg;
        rx_perr_next = rx_perr_reg;
        rx_push_req = 1'b0;
        unique case (rx_state_reg)
            USPR_RX_IDLE: begin
                // start needs a falling edge: a low stop bit cannot restart
                if (rx_prev_reg && !rx_in) begin
                    rx_par_next = 1'b0;
                    rx_perr_next = 1'b0;
                    rx_state_next = USPR_RX_START;
                end
            end
            USPR_RX_START: begin
                if (rx_sample) begin
                    rx_bit_next = 3'd0;
                    rx_state_next = rx_in ? USPR_RX_IDLE : USPR_RX_DATA;
                end
            end
            USPR_RX_DATA: begin
                if (rx_sample) begin
                    rx_shift_next = {rx_in, rx_shift_reg[7:1]};
                    rx_par_next = rx_par_reg ^ rx_in;
                    rx_bit_next = rx_bit_reg + 3'd1;
                    if (rx_bit_reg == last_bit) begin
                        rx_state_next = par_en ? USPR_RX_PAR : USPR_RX_STOP;
                    end
                end
            end
            USPR_RX_PAR: begin
                if (rx_sample) begin
                    rx_perr_next = (rx_par_reg ^ rx_in) != odd_sel;
                    rx_state_next = USPR_RX_STOP;
                end
            end
            USPR_RX_STOP: begin
                if (rx_sample) begin
                    rx_push_req = 1'b1;
                    rx_state_next = USPR_RX_IDLE;
                end
            end
        endcase
    end

    // ---- receive fifo and error flags
    wire rx_full = rxf_cnt_reg == DEPTH;
    wire rx_pop = rd_data & (rxf_cnt_reg != 3'd0);
    wire rx_push = rx_push_req & (~rx_full | rx_pop);
    wire ovf_next = (rx_push_req & rx_full & ~rx_pop)
                    | (ovf_reg & ~rd_data);
    wire [9:0] rx_after = rxf_mem[rxf_rd_reg + 2'd1];
    wire err_load = rx_pop | (rx_push & (rxf_cnt_reg == 3'd0));
    wire [1:0] err_val = (rx_pop && rxf_cnt_reg > 3'd1) ? rx_after[9:8]
                         : rx_push ? rx_word[9:8] : 2'b00;
    wire rts_n_next = ~flow ? 1'b0
                      : auto_rts ? (rxf_cnt_reg >= DEPTH - 3'd1)
                      : ~cfg_reg[`USPR_CF_RTS];

    wire [31:0] stat_word = {25'h0, tx_idle_flag, par_err_reg, frm_err_reg,
                             ovf_reg, tx_space_reg,
                             rxf_cnt_reg != 3'd0,
                             flow & ~clear_to_send_in_n};
    wire [31:0] rd_word =
        uspr_hit(s_axi_araddr, `USPR_OFF_STAT) ? stat_word
        : uspr_hit(s_axi_araddr, `USPR_OFF_CFG) ? {25'h0, cfg_reg}
        : uspr_hit(s_axi_araddr, `USPR_OFF_PER) ? {16'h0, per_reg}
        : uspr_hit(s_axi_araddr, `USPR_OFF_FRAC) ? {31'h0, frac_reg}
        : rx_pop ? {24'h0, rxf_mem[rxf_rd_reg][7:0]} : 32'h0;

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_reg <= `USPR_CFG_RESET;
            per_reg <= `USPR_PER_RESET;
            frac_reg <= `USPR_FRAC_RESET;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `USPR_RESP_OKAY;
            awaddr_reg <= 16'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= `USPR_RESP_OKAY;
            rdata_reg <= 32'h0;
        end else if (ce) begin
            if (aw_hs) awaddr_reg <= s_axi_awaddr;
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= ~aw_full_next & ~bvalid_next;
            wready_reg <= ~w_full_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_write) bresp_reg <= wr_ok ? `USPR_RESP_OKAY
                                             : `USPR_RESP_SLVERR;
            if (wr_cfg && wstrb_reg[0]) cfg_reg <= wdata_reg[6:0];
            if (wr_per && wstrb_reg[0]) per_reg[7:0] <= wdata_reg[7:0];
            if (wr_per && wstrb_reg[1]) per_reg[15:8] <= wdata_reg[15:8];
            if (wr_frac && wstrb_reg[0]) frac_reg <= wdata_reg[0];
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_hs) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_ok ? `USPR_RESP_OKAY : `USPR_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ref_acc_reg <= 8'h0;
            txf_wr_reg <= '0;
            txf_rd_reg <= '0;
            txf_cnt_reg <= 3'd0;
            rxf_wr_reg <= '0;
            rxf_rd_reg <= '0;
            rxf_cnt_reg <= 3'd0;
            ovf_reg <= 1'b0;
            par_err_reg <= 1'b0;
            frm_err_reg <= 1'b0;
            rts_n_reg <= 1'b0;
            tx_space_reg <= 1'b0;
        end else if (ce) begin
            ref_acc_reg <= ref_acc_next;
            if (tx_push) txf_wr_reg <= txf_wr_reg + 2'd1;
            if (tx_pop) txf_rd_reg <= txf_rd_reg + 2'd1;
            txf_cnt_reg <= txf_cnt_next;
            tx_space_reg <= txf_cnt_next != DEPTH;
            if (rx_push) rxf_wr_reg <= rxf_wr_reg + 2'd1;
            if (rx_pop) rxf_rd_reg <= rxf_rd_reg + 2'd1;
            rxf_cnt_reg <= rxf_cnt_reg + {2'b0, rx_push} - {2'b0, rx_pop};
            ovf_reg <= ovf_next;
            if (err_load) begin
                par_err_reg <= err_val[0];
                frm_err_reg <= err_val[1];
            end
            rts_n_reg <= rts_n_next;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && tx_push) txf_mem[txf_wr_reg] <= wdata_reg[7:0];
        if (ce && rx_push) rxf_mem[rxf_wr_reg] <= rx_word;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_state_reg <= USPR_TX_IDLE;
            tx_tim_reg <= 17'h0;
            tx_shift_reg <= 8'h0;
            tx_bit_reg <= 3'd0;
            tx_par_reg <= 1'b0;
            tx_out_reg <= 1'b1;
            rx_state_reg <= USPR_RX_IDLE;
            rx_tim_reg <= 17'h0;
            rx_shift_reg <= 8'h0;
            rx_bit_reg <= 3'd0;
            rx_par_reg <= 1'b0;
            rx_perr_reg <= 1'b0;
            rx_prev_reg <= 1'b1;
        end else if (ce) begin
            tx_state_reg <= tx_state_next;
            if (tx_state_next != tx_state_reg || tx_bit_end) begin
                tx_tim_reg <= 17'h0;
            end else if (ref_tick) begin
                tx_tim_reg <= tx_tim_reg + 17'h1;
            end
            tx_shift_reg <= tx_shift_next;
            tx_bit_reg <= tx_bit_next;
            tx_par_reg <= tx_par_next;
            tx_out_reg <= tx_out_next;
            rx_state_reg <= rx_state_next;
            if (rx_state_reg == USPR_RX_IDLE || rx_sample) begin
                rx_tim_reg <= 17'h0;
            end else if (ref_tick) begin
                rx_tim_reg <= rx_tim_reg + 17'h1;
            end
            rx_shift_reg <= rx_shift_next;
            rx_bit_reg <= rx_bit_next;
            rx_par_reg <= rx_par_next;
            rx_perr_reg <= rx_perr_next;
            rx_prev_reg <= rx_in;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign tx_out = tx_out_reg;
    assign request_to_send_out_n = rts_n_reg;

    // ---- checks
    AST_TXIDLE: assert property (@(posedge clk) disable iff (reset || !ce)
        rd_stat |=> (rdata_reg[6] == $past(txf_cnt_reg == 3'd0
                     && tx_state_reg == USPR_TX_IDLE)))
        else $error("tx idle flag wrong on status read");
    AST_ERR_EMPTY: assert property (@(posedge clk) disable iff (reset)
        (rxf_cnt_reg == 3'd0) |-> (!par_err_reg && !frm_err_reg))
        else $error("error flags set with empty rx fifo");
    AST_OVF_SET: assert property (@(posedge clk) disable iff (reset || !ce)
        (rx_push_req && rx_full && !rd_data) |=> ovf_reg)
        else $error("overrun not flagged");
    AST_OVF_CLR: assert property (@(posedge clk) disable iff (reset || !ce)
        (rd_data && !rx_push_req) |=> !ovf_reg)
        else $error("overrun not cleared by data read");
    AST_RTS_AUTO: assert property (@(posedge clk) disable iff (reset || !ce)
        (flow && auto_rts) |=> (request_to_send_out_n ==
                                ($past(rxf_cnt_reg) >= DEPTH - 3'd1)))
        else $error("auto request-to-send level wrong");
    AST_RTS_MAN: assert property (@(posedge clk) disable iff (reset || !ce)
        (flow && !auto_rts) |=> (request_to_send_out_n
                                 == !$past(cfg_reg[0])))
        else $error("manual request-to-send level wrong");
    AST_CTS_HOLD: assert property (@(posedge clk) disable iff (reset || !ce)
        (tx_state_reg == USPR_TX_IDLE && flow && clear_to_send_in_n)
        |=> (tx_state_reg == USPR_TX_IDLE && $stable(txf_rd_reg)))
        else $error("transmit started while clear-to-send deasserted");
    AST_STAT_RST: assert property (@(posedge clk)
        $past(reset) |-> (stat_word == `USPR_STAT_RESET))
        else $error("status not at reset value");
    AST_BIT_TIME: assert property (@(posedge clk) disable iff (reset || !ce)
        (tx_state_reg != USPR_TX_IDLE) |-> (tx_tim_reg <= div_last))
        else $error("transmit bit timer beyond divisor");
endmodule : uspr_top

// *** inc/uspr_pkg.sv ***
// types shared by the serial port design
package uspr_pkg;
    typedef enum logic [2:0] {
        USPR_TX_IDLE, USPR_TX_START, USPR_TX_DATA, USPR_TX_PAR, USPR_TX_STOP
    } uspr_tx_state_t;
    typedef enum logic [2:0] {
        USPR_RX_IDLE, USPR_RX_START, USPR_RX_DATA, USPR_RX_PAR, USPR_RX_STOP
    } uspr_rx_state_t;
endpackage : uspr_pkg

// *** inc/uspr_regs.svh ***
// register offsets, field positions, reset values and timing for the serial port
`ifndef USPR_REGS_SVH
`define USPR_REGS_SVH
`define USPR_ADDR_W 16
`define USPR_OFF_DATA 16'hc83c
`define USPR_OFF_STAT 16'hc848
`define USPR_OFF_CFG 16'hc85c
`define USPR_OFF_PER 16'hc868
`define USPR_OFF_FRAC 16'hc86c
`define USPR_STAT_RESET 32'h0000_0040
`define USPR_CFG_RESET 7'h00
`define USPR_PER_RESET 16'h0000
`define USPR_FRAC_RESET 1'b0
`define USPR_ST_TXIDLE 6
`define USPR_ST_PARERR 5
`define USPR_ST_FRMERR 4
`define USPR_ST_RXOVF 3
`define USPR_ST_TXFREE 2
`define USPR_ST_RXVAL 1
`define USPR_ST_CTS 0
`define USPR_CF_AUTO 6
`define USPR_CF_FLOW 5
`define USPR_CF_ODD 4
`define USPR_CF_PAR 3
`define USPR_CF_TWOSTP 2
`define USPR_CF_EIGHT 1
`define USPR_CF_RTS 0
`define USPR_CLK_MHZ 125
`define USPR_REF_MHZ 24
`define USPR_FIFO_DEPTH 4
`define USPR_PTR_W 2
`define USPR_RESP_OKAY 2'h0
`define USPR_RESP_SLVERR 2'h2
`endif

// *** tb/tb_top.sv ***
// bench: register tasks, serial partner, queued result checks
`timescale 1ns/100ps
`include "uspr_regs.svh"
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic clear_to_send_in_n = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rx_in, tx_out, request_to_send_out_n, got;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [8:0] got_bits;
    logic [7:0] b [5];
    logic [7:0] m;
    logic [4:0] cfg_v = 5'h00;
    logic [4:0] txc [5] = '{5'h0a, 5'h1a, 5'h02, 5'h0c, 5'h18};
    logic [34:0] rq [$];
    logic [8:0] sq [$];
    int n_mismatch = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    uspr_top dut_u (.clk, .reset, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in, .tx_out,
        .clear_to_send_in_n, .request_to_send_out_n);
    uspr_remote #(.BIT_CLKS(47)) remote_u (.clk, .tx_out,
        .request_to_send_out_n, .cfg(cfg_v), .rx_in, .got, .got_bits);
    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    // a note is queued per read; the watcher compares flagged notes when data returns
    task automatic rd(input logic [15:0] a, input logic [33:0] e, input logic c);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        rq.push_back({c, e});
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic chk(input logic [15:0] a, input logic [31:0] e);
        rd(a, {2'h0, e}, 1'b1);
    endtask : chk
    task automatic pin(input logic e);
        repeat (2) @(posedge clk);
        cmp(34'(request_to_send_out_n), 34'(e));
    endtask : pin
    task automatic idle();
        rv = 32'h0;
        for (int t = 0; t < 400 && !(rv[6] === 1'b1 && sq.size() == 0); t++)
            rd(`USPR_OFF_STAT, 34'h0, 1'b0);
    endtask : idle
    always @(posedge clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready && rq.size() > 0) begin
            if (rq[0][34]) cmp({s_axi_rresp, s_axi_rdata}, rq[0][33:0]);
            void'(rq.pop_front());
        end
        if (got === 1'b1) cmp(34'(got_bits), 34'(sq.pop_front()));
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        void'($urandom(43293));
        for (int i = 0; i < 5; i++) b[i] = 8'($urandom);
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        chk(`USPR_OFF_STAT, 32'h44);
        chk(`USPR_OFF_CFG, 32'h0);
        chk(`USPR_OFF_PER, 32'h0);
        rd(16'hc800, {`USPR_RESP_SLVERR, 32'h0}, 1'b1);
        wr(`USPR_OFF_PER, 32'h4);
        wr(`USPR_OFF_FRAC, 32'h1);
        chk(`USPR_OFF_FRAC, 32'h1);
        for (int i = 0; i < 5; i++) begin
            cfg_v = txc[i];
            wr(`USPR_OFF_CFG, {27'h0, txc[i]});
            m = cfg_v[1] ? 8'hff : 8'h7f;
            sq.push_back({cfg_v[3] & (^(b[i] & m) ^ cfg_v[4]), b[i] & m});
            wr(`USPR_OFF_DATA, {24'h0, b[i]});
            chk(`USPR_OFF_STAT, 32'h04);
            idle();
            chk(`USPR_OFF_STAT, 32'h44);
        end
        cfg_v = 5'h0a;
        wr(`USPR_OFF_CFG, 32'h0a);
        remote_u.send(b[0], 1'b1, 1'b0);
        chk(`USPR_OFF_STAT, 32'h66);
        remote_u.send(b[1], 1'b0, 1'b1);
        chk(`USPR_OFF_STAT, 32'h66);
        chk(`USPR_OFF_DATA, {24'h0, b[0]});
        chk(`USPR_OFF_STAT, 32'h56);
        chk(`USPR_OFF_DATA, {24'h0, b[1]});
        chk(`USPR_OFF_STAT, 32'h44);
        for (int i = 0; i < 5; i++) remote_u.send(b[i], 1'b0, 1'b0);
        chk(`USPR_OFF_STAT, 32'h4e);
        chk(`USPR_OFF_DATA, {24'h0, b[0]});
        chk(`USPR_OFF_STAT, 32'h46);
        for (int i = 1; i < 4; i++) chk(`USPR_OFF_DATA, {24'h0, b[i]});
        wr(`USPR_OFF_CFG, 32'h2b);
        pin(1'b0);
        wr(`USPR_OFF_CFG, 32'h2a);
        pin(1'b1);
        wr(`USPR_OFF_CFG, 32'h6a);
        pin(1'b0);
        for (int i = 0; i < 3; i++) remote_u.send(b[i], 1'b0, 1'b0);
        pin(1'b1);
        chk(`USPR_OFF_DATA, {24'h0, b[0]});
        pin(1'b0);
        chk(`USPR_OFF_DATA, {24'h0, b[1]});
        chk(`USPR_OFF_DATA, {24'h0, b[2]});
        wr(`USPR_OFF_CFG, 32'h2b);
        clear_to_send_in_n <= 1'b1;
        sq.push_back({^b[4], b[4]});
        wr(`USPR_OFF_DATA, {24'h0, b[4]});
        repeat (600) @(posedge clk);
        chk(`USPR_OFF_STAT, 32'h04);
        cmp(34'(sq.size()), 34'h1);
        clear_to_send_in_n <= 1'b0;
        chk(`USPR_OFF_STAT, 32'h05);
        idle();
        report_and_stop();
    end
endmodule : tb_top

// *** tb/uspr_remote.sv ***
// remote serial device model: frames bytes onto rx_in, decodes tx_out
`timescale 1ns/100ps
module uspr_remote #(
    parameter int BIT_CLKS = 47
) (
    input wire logic clk,
    input wire logic tx_out,
    input wire logic request_to_send_out_n,
    input wire logic [4:0] cfg,
    output logic rx_in,
    output logic got,
    output logic [8:0] got_bits
);
    logic [7:0] acc;
    logic par;
    initial begin
        rx_in = 1'b1;
        got = 1'b0;
        got_bits = 9'h000;
    end
    task automatic bit_out(input logic v);
        rx_in <= v;
        repeat (BIT_CLKS) @(posedge clk);
    endtask : bit_out
    // bp spoils the parity bit, bs spoils the stop bit
    task automatic send(input logic [7:0] b, input logic bp, input logic bs);
        logic [7:0] m;
        m = cfg[1] ? 8'hff : 8'h7f;
        while (request_to_send_out_n !== 1'b0) @(posedge clk);
        @(posedge clk);
        bit_out(1'b0);
        for (int k = 0; k < (cfg[1] ? 8 : 7); k++) bit_out(b[k]);
        if (cfg[3]) bit_out(^(b & m) ^ cfg[4] ^ bp);
        bit_out(~bs);
        rx_in <= 1'b1;
    endtask : send
    always begin
        @(negedge tx_out);
        repeat (BIT_CLKS / 2) @(posedge clk);
        acc = 8'h00;
        par = 1'b0;
        for (int k = 0; k < (cfg[1] ? 8 : 7); k++) begin
            repeat (BIT_CLKS) @(posedge clk);
            acc[k] = tx_out;
        end
        if (cfg[3]) begin
            repeat (BIT_CLKS) @(posedge clk);
            par = tx_out;
        end
        got_bits <= {par, acc};
        got <= 1'b1;
        @(posedge clk);
        got <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
    end
endmodule : uspr_remote
